/* dv/rau_core_props.sv */
// port-level assertions for the register space core
`timescale 1ns/1ps
`default_nettype none
`include "rau_regs.vh"
module rau_core_props (
	input wire mclk_i,
	input wire rst_n_i,
	input wire phase_a_clock_output_o,
	input wire in_reset_o,
	input wire op_valid_i,
	input wire op_ready_o,
	input wire [2:0] op_code_i,
	input wire [7:0] op_src_i,
	input wire op_done_o,
	input wire [15:0] result_o,
	input wire sfr_rd_o,
	input wire sfr_wr_o,
	input wire [7:0] sfr_addr_o,
	input wire fetch_req_o,
	input wire fetch_ext_o,
	input wire [7:0] abus_o,
	input wire abus_hi_o,
	input wire [15:0] program_counter_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [5:0] rel_cnt;
	logic [2:0] last_code;
	logic [7:0] last_src;
	wire take = op_valid_i && op_ready_o;
	wire ph = phase_a_clock_output_o;
	// saturating count of edges since reset release
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rel_cnt <= 6'h00;
			last_code <= 3'h0;
			last_src <= 8'h00;
		end else begin
			if (rel_cnt != 6'h3F) begin
				rel_cnt <= rel_cnt + 6'h01;
			end
			if (take) begin
				last_code <= op_code_i;
				last_src <= op_src_i;
			end
		end
	end
	property p_phase_cycle;
		$rose(ph) |=> !ph ##1 !ph ##1 ph;
	endproperty
	a_phase_cycle: assert property (p_phase_cycle)
		else $error("phase a period wrong");
	property p_phase_restart;
		rel_cnt == 6'h00 |-> ##[0:1] (ph ##1 !ph ##1 !ph);
	endproperty
	a_phase_restart: assert property (p_phase_restart)
		else $error("phase a not first after reset");
	property p_reset_len;
		$fell(in_reset_o) |-> rel_cnt >= 6'h1D && rel_cnt <= 6'h1F;
	endproperty
	a_reset_len: assert property (p_reset_len)
		else $error("start delay wrong");
	property p_first_fetch;
		$fell(in_reset_o) |->
			##[0:4] (fetch_req_o && program_counter_o == `RAU_RESET_VECTOR);
	endproperty
	a_first_fetch: assert property (p_first_fetch)
		else $error("first fetch missing");
	property p_no_op_in_reset;
		in_reset_o |-> !op_ready_o;
	endproperty
	a_no_op_in_reset: assert property (p_no_op_in_reset)
		else $error("ready while in reset");
	property p_fetch_ext;
		fetch_req_o |-> fetch_ext_o == (program_counter_o <= 16'h00FF);
	endproperty
	a_fetch_ext: assert property (p_fetch_ext)
		else $error("fetch target wrong");
	property p_abus_order;
		$rose(fetch_req_o) |-> abus_hi_o && abus_o == program_counter_o[15:8]
			##1 !abus_hi_o && abus_o == program_counter_o[7:0];
	endproperty
	a_abus_order: assert property (p_abus_order)
		else $error("narrow bus byte order wrong");
	property p_done_lat;
		take && op_code_i < `RAU_OP_SHL |-> ##[3:4] op_done_o;
	endproperty
	a_done_lat: assert property (p_done_lat)
		else $error("operation latency wrong");
	property p_shift_bound;
		take && op_code_i >= `RAU_OP_SHL |-> ##[3:40] op_done_o;
	endproperty
	a_shift_bound: assert property (p_shift_bound)
		else $error("shift not bounded");
	property p_zero;
		op_done_o && last_code == `RAU_OP_PASS && last_src <= 8'h01
			|-> result_o == 16'h0000;
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero register not zero");
	property p_window;
		sfr_wr_o || sfr_rd_o |-> sfr_addr_o <= `RAU_SFR_LAST;
	endproperty
	a_window: assert property (p_window)
		else $error("window access outside window");
endmodule // rau_core_props
bind rau_core rau_core_props rau_core_props_i (.mclk_i, .rst_n_i,
	.phase_a_clock_output_o, .in_reset_o, .op_valid_i, .op_ready_o,
	.op_code_i, .op_src_i, .op_done_o, .result_o, .sfr_rd_o, .sfr_wr_o,
	.sfr_addr_o, .fetch_req_o, .fetch_ext_o, .abus_o, .abus_hi_o,
	.program_counter_o);
`default_nettype wire

/* dv/rau_core_tb_top.sv */
// self-checking bench for the register space core
`timescale 1ns/1ps
`default_nettype none
`include "rau_regs.vh"
module rau_core_tb_top;
	logic mclk_i, rst_n_i, op_valid_i, op_push_i, op_pop_i, op_jump_i;
	logic fetch_ack_i, slow, phase_a, in_reset_o, op_ready_o, op_done_o;
	logic win_rd, win_wr, fetch_req, fetch_ext, abus_hi, fetch_is_ext;
	logic [2:0] op_code_i;
	logic [1:0] op_size_i;
	logic [4:0] op_shift_i;
	logic [7:0] op_dst_i, op_src_i, win_addr, win_a, abus, fetch_cnt, c0;
	logic [7:0] rd_addr;
	logic [15:0] op_jump_offs_i, result_o, program_status_word, sp, sfr_rdata_i, win_data;
	logic [15:0] pc, fetch_addr, win_wd, a, b;
	int num_errors, total_checks, n;
	rau_core rau_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.phase_a_clock_output_o(phase_a), .in_reset_o(in_reset_o),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_dst_i(op_dst_i),
		.op_src_i(op_src_i), .op_size_i(op_size_i), .op_shift_i(op_shift_i),
		.op_push_i(op_push_i), .op_pop_i(op_pop_i), .op_jump_i(op_jump_i),
		.op_jump_offs_i(op_jump_offs_i), .op_ready_o(op_ready_o),
		.op_done_o(op_done_o), .result_o(result_o),
		.program_status_word_o(program_status_word), .stack_pointer_o(sp), .sfr_rd_o(win_rd),
		.sfr_wr_o(win_wr), .sfr_addr_o(win_a), .sfr_wdata_o(win_wd),
		.sfr_rdata_i(sfr_rdata_i), .fetch_req_o(fetch_req),
		.fetch_ext_o(fetch_ext), .abus_o(abus), .abus_hi_o(abus_hi),
		.program_counter_o(pc), .fetch_ack_i(fetch_ack_i));
	rau_mem_ctrl rau_mem_ctrl_i (.mclk_i(mclk_i), .slow_i(slow),
		.fetch_req_i(fetch_req), .fetch_ext_i(fetch_ext), .abus_i(abus),
		.abus_hi_i(abus_hi), .fetch_ack_o(fetch_ack_i), .addr_o(fetch_addr),
		.ext_o(fetch_is_ext), .count_o(fetch_cnt));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (win_wr === 1'b1) begin
			win_addr <= win_a;
			win_data <= win_wd;
		end
		if (win_rd === 1'b1) begin
			rd_addr <= win_a;
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge mclk_i);
		#1;
		n++;
		if (n > 400) begin
			num_errors++;
			report_and_stop();
		end
	endtask
	task automatic run_op(input logic [2:0] c, input logic [7:0] d, s);
		n = 0;
		while (op_ready_o !== 1'b1) tick();
		op_code_i = c;
		op_dst_i = d;
		op_src_i = s;
		op_valid_i = 1'b1;
		tick();
		op_valid_i = 1'b0;
		while (op_done_o !== 1'b1) tick();
	endtask
	task automatic load(input logic [7:0] d, input logic [15:0] v);
		sfr_rdata_i = v;
		run_op(`RAU_OP_PASS, d, 8'h05);
	endtask
	task automatic do_reset();
		rst_n_i = 1'b0;
		repeat (10) @(posedge mclk_i);
		#1;
		check({15'h0, in_reset_o}, 16'h0001);
		check(pc, `RAU_RESET_VECTOR);
		c0 = fetch_cnt;
		rst_n_i = 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge mclk_i);
			#1;
			n += int'(phase_a === 1'b1);
		end
		check(16'(n), 16'h000A);
		n = 0;
		while (fetch_cnt == c0 || op_ready_o !== 1'b1) tick();
		check(fetch_addr, `RAU_RESET_VECTOR);
		check({15'h0, fetch_is_ext}, 16'h0000);
		$display("reset test done");
	endtask
	function automatic logic [15:0] alu(input logic [2:0] c,
		input logic [15:0] x, y, input logic [4:0] k);
		case (c)
			`RAU_OP_SHL: return y << k;
			`RAU_OP_SHR: return y >> k;
			`RAU_OP_ADD: return x + y;
			`RAU_OP_SUB: return x - y;
			`RAU_OP_AND: return x & y;
			`RAU_OP_OR: return x | y;
			`RAU_OP_XOR: return x ^ y;
			default: return y;
		endcase
	endfunction
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n_i, op_valid_i, op_push_i, op_pop_i, op_jump_i, slow} = 6'h00;
		{op_code_i, op_dst_i, op_src_i, op_shift_i} = 24'h000000;
		op_size_i = 2'h1;
		op_jump_offs_i = 16'h0000;
		sfr_rdata_i = 16'h0000;
		num_errors = 0;
		total_checks = 0;
		void'($urandom(32'haec2));
		do_reset();
		for (int i = 0; i < 24; i++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			slow = 1'($urandom);
			op_shift_i = (i == 7) ? 5'h1F : 5'($urandom);
			load(8'h40, a);
			load(8'h50, b);
			run_op(3'(i), 8'h40, 8'h50);
			if (3'(i) < `RAU_OP_SHL) check(result_o, alu(3'(i), a, b, 5'h00));
			else check(result_o, alu(3'(i), a, b, op_shift_i));
		end
		load(8'h40, 16'hFFFF);
		load(8'h50, 16'h0001);
		run_op(`RAU_OP_ADD, 8'h40, 8'h50);
		check({result_o[15:2], program_status_word[1:0]}, 16'h0003);
		$display("alu test done");
		load(8'h00, 16'hA5A5);
		run_op(`RAU_OP_PASS, 8'h40, 8'h00);
		check(result_o, 16'h0000);
		a = 16'($urandom);
		load(8'h40, a);
		run_op(`RAU_OP_PASS, 8'h10, 8'h40);
		tick();
		check({8'h00, win_addr}, 16'h0010);
		check(win_data, a);
		run_op(`RAU_OP_PASS, 8'h50, 8'h16);
		check({8'h00, rd_addr}, 16'h0016);
		a = 16'($urandom) & 16'hFFFE;
		load(8'h18, a);
		check(sp, a);
		op_push_i = 1'b1;
		run_op(`RAU_OP_PASS, 8'h40, 8'h40);
		op_push_i = 1'b0;
		check(sp, a - 16'h0002);
		op_pop_i = 1'b1;
		run_op(`RAU_OP_PASS, 8'h40, 8'h40);
		op_pop_i = 1'b0;
		check(sp, a);
		$display("space test done");
		n = 0;
		while (op_ready_o !== 1'b1) tick();
		op_jump_i = 1'b1;
		op_jump_offs_i = 16'h0050 - pc;
		run_op(`RAU_OP_PASS, 8'h40, 8'h40);
		op_jump_i = 1'b0;
		n = 0;
		while (op_ready_o !== 1'b1) tick();
		check(fetch_addr, 16'h0050);
		check({15'h0, fetch_is_ext}, 16'h0001);
		$display("jump test done");
		a = 16'($urandom);
		load(8'hF5, a);
		do_reset();
		run_op(`RAU_OP_PASS, 8'h40, 8'hF5);
		check(result_o, a);
		$display("retention test done");
		report_and_stop();
	end
	initial begin
		#300000;
		num_errors++;
		report_and_stop();
	end
endmodule // rau_core_tb_top
`default_nettype wire

/* dv/rau_mem_ctrl.sv */
// memory controller model answering core fetches
`timescale 1ns/1ps
`default_nettype none
module rau_mem_ctrl (
	input wire logic mclk_i,
	input wire logic slow_i,
	input wire logic fetch_req_i,
	input wire logic fetch_ext_i,
	input wire logic [7:0] abus_i,
	input wire logic abus_hi_i,
	output logic fetch_ack_o,
	output logic [15:0] addr_o,
	output logic ext_o,
	output logic [7:0] count_o
);
	logic [3:0] wait_cnt;
	logic got_lo;
	initial begin
		fetch_ack_o = 1'b0;
		addr_o = 16'h0000;
		ext_o = 1'b0;
		count_o = 8'h00;
		wait_cnt = 4'h0;
		got_lo = 1'b0;
	end
	// slow mode stretches the answer like a waited external cycle
	always @(posedge mclk_i) begin
		if (!fetch_req_i) begin
			fetch_ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			got_lo <= 1'b0;
		end else if (!fetch_ack_o) begin
			wait_cnt <= wait_cnt + 4'h1;
			if (abus_hi_i) begin
				addr_o[15:8] <= abus_i;
			end else if (!got_lo) begin
				addr_o[7:0] <= abus_i;
				ext_o <= fetch_ext_i;
				got_lo <= 1'b1;
				count_o <= count_o + 8'h01;
			end
			if (got_lo && wait_cnt >= (slow_i ? 4'h6 : 4'h1)) begin
				fetch_ack_o <= 1'b1;
			end
		end
	end
endmodule // rau_mem_ctrl
`default_nettype wire

/* rtl/rau_core.v */
// register space, arithmetic unit and reset timing of the core
//
// Function
// - oscillator divided by three into three phases
// - phase a only driven out on clock pin
// - 232 ram bytes, byte or word access, double writes a word
// - addresses 01h-17h decode as special window
// - 18h-19h stack pointer, else plain ram
// - stack grows down, software sets pointer
// - fetches below 100h go to external memory
// - any of 256 locations is an operand
// - 16-bit data bus unit to registers only
// - 8-bit bus carries fetch addresses, high byte first
// - 17-bit alu, status, counter, loop, temporaries
// - own incrementer for counter, jumps via own adder
// - two shifting temporaries, low only for double
// - shift steps counted by 5-bit loop counter
// - zero register reads zero as source on data bus, not as first operand
// - fully in reset at once on rst_n_i
// - first fetch at 2080h ten states after release
// - top 16 ram bytes kept through reset
// - special addresses split read and write functions
`timescale 1ns/1ps
`default_nettype none
`include "rau_regs.vh"
module rau_core #(
	parameter LOOP_W = 5
) (
	input wire mclk_i,
	input wire rst_n_i,
	output wire phase_a_clock_output_o,
	output wire in_reset_o,
	// operation request from the control unit
	input wire op_valid_i,
	input wire [2:0] op_code_i,
	input wire [7:0] op_dst_i,
	input wire [7:0] op_src_i,
	input wire [1:0] op_size_i,
	input wire [4:0] op_shift_i,
	input wire op_push_i,
	input wire op_pop_i,
	input wire op_jump_i,
	input wire [15:0] op_jump_offs_i,
	output wire op_ready_o,
	output reg op_done_o,
	output reg [15:0] result_o,
	output reg [15:0] program_status_word_o,
	output reg [15:0] stack_pointer_o,
	// special function window, read and write split
	output reg sfr_rd_o,
	output reg sfr_wr_o,
	output reg [7:0] sfr_addr_o,
	output reg [15:0] sfr_wdata_o,
	input wire [15:0] sfr_rdata_i,
	// narrow bus towards the memory controller
	output reg fetch_req_o,
	output reg fetch_ext_o,
	output reg [7:0] abus_o,
	output reg abus_hi_o,
	output reg [15:0] program_counter_o,
	input wire fetch_ack_i
);
	// ------------------------------------------------------------
	// phases and reset sequencing
	// ------------------------------------------------------------
	wire ph_a;
	wire ph_b;
	wire ph_c;
	wire st_end;
	rau_phase_gen u_phase (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.phase_a_o(ph_a),
		.phase_b_o(ph_b),
		.phase_c_o(ph_c),
		.state_end_o(st_end)
	);
	assign phase_a_clock_output_o = ph_a;

	// rst_n_i clears the sequencer at once; the start count then
	// runs ten state times before the first fetch
	reg [3:0] start_cnt_reg;
	reg run_reg;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_cnt_reg <= 4'h0;
			run_reg <= 1'b0;
		end else if (!run_reg && st_end) begin
			if (start_cnt_reg == `RAU_START_STATES - 4'h1) begin
				run_reg <= 1'b1;
			end else begin
				start_cnt_reg <= start_cnt_reg + 4'h1;
			end
		end
	end
	assign in_reset_o = !run_reg;

	// ------------------------------------------------------------
	// operand address decode
	// ------------------------------------------------------------
	wire src_sfr = (op_src_i <= `RAU_SFR_LAST) && (op_src_i != 8'h00);
	wire dst_sfr = (op_dst_i <= `RAU_SFR_LAST) && (op_dst_i != 8'h00);
	wire src_zero = (op_src_i == `RAU_ZERO_REG) ||
		(op_src_i == 8'h01);

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_READ = 3'h1;
	localparam ST_EXEC = 3'h2;
	localparam ST_SHIFT = 3'h3;
	localparam ST_WRITE = 3'h4;
	localparam ST_FETCH = 3'h5;
	localparam ST_FLO = 3'h6;
	reg [2:0] state_reg;
	reg [2:0] op_reg;
	reg [7:0] dst_reg;
	reg [7:0] src_reg;
	reg [1:0] size_reg;
	reg src_sfr_reg;
	reg dst_sfr_reg;
	reg src_zero_reg;
	reg push_reg;
	reg pop_reg;
	reg jump_reg;
	reg [15:0] offs_reg;
	reg [16:0] tmp_a_reg; // first operand, 17 bits
	reg [16:0] upper_reg; // upper word, shifts always
	reg [15:0] lower_reg; // lower word, double shifts only
	reg [LOOP_W-1:0] loop_reg;
	reg [15:0] pc_reg;

	// ram ports
	reg [7:0] ram_raddr;
	reg [7:0] ram_waddr;
	reg [15:0] ram_wdata;
	reg [1:0] ram_wbe;
	wire [15:0] ram_rdata;
	rau_reg_ram #(
		.DEPTH(256)
	) u_ram (
		.mclk_i(mclk_i),
		.raddr_i(ram_raddr),
		.rdata_o(ram_rdata),
		.waddr_i(ram_waddr),
		.wdata_i(ram_wdata),
		.wbe_i(ram_wbe)
	);

	// held low until the first fetch has been issued, so an op offered
	// in the idle cycle that starts that fetch is never lost
	assign op_ready_o = run_reg && (state_reg == ST_IDLE) &&
		program_status_word_o[15];

	// operand seen on the 16-bit data bus
	wire [15:0] dbus = src_zero_reg ? 16'h0000 :
		(src_sfr_reg ? sfr_rdata_i : ram_rdata);

	// ------------------------------------------------------------
	// 17-bit alu
	// ------------------------------------------------------------
	reg [16:0] alu_out;
	always @* begin
		case (op_reg)
		`RAU_OP_ADD: alu_out = tmp_a_reg + {1'b0, dbus};
		`RAU_OP_SUB: alu_out = tmp_a_reg - {1'b0, dbus};
		`RAU_OP_AND: alu_out = tmp_a_reg & {1'b0, dbus};
		`RAU_OP_OR: alu_out = tmp_a_reg | {1'b0, dbus};
		`RAU_OP_XOR: alu_out = tmp_a_reg ^ {1'b0, dbus};
		default: alu_out = {1'b0, dbus};
		endcase
	end
	// jump target from its own adder, not the alu or the pc incrementer
	wire [16:0] jump_sum = {1'b0, pc_reg} + {1'b0, offs_reg};
	wire [15:0] pc_inc = pc_reg + 16'h0001;
	wire [15:0] sp_dec = stack_pointer_o - 16'h0002;
	wire [15:0] sp_inc = stack_pointer_o + 16'h0002;
	wire is_shift = (op_reg == `RAU_OP_SHL) || (op_reg == `RAU_OP_SHR);
	wire dbl = (size_reg == 2'h2);

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			op_reg <= 3'h0;
			dst_reg <= 8'h00;
			src_reg <= 8'h00;
			size_reg <= 2'h0;
			src_sfr_reg <= 1'b0;
			dst_sfr_reg <= 1'b0;
			src_zero_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			jump_reg <= 1'b0;
			offs_reg <= 16'h0000;
			tmp_a_reg <= 17'h00000;
			upper_reg <= 17'h00000;
			lower_reg <= 16'h0000;
			loop_reg <= {LOOP_W{1'b0}};
			pc_reg <= `RAU_RESET_VECTOR;
			op_done_o <= 1'b0;
			result_o <= 16'h0000;
			program_status_word_o <= 16'h0000;
			stack_pointer_o <= 16'h0000;
			sfr_rd_o <= 1'b0;
			sfr_wr_o <= 1'b0;
			sfr_addr_o <= 8'h00;
			sfr_wdata_o <= 16'h0000;
			fetch_req_o <= 1'b0;
			fetch_ext_o <= 1'b0;
			abus_o <= 8'h00;
			abus_hi_o <= 1'b0;
			program_counter_o <= `RAU_RESET_VECTOR;
		end else begin
			op_done_o <= 1'b0;
			sfr_rd_o <= 1'b0;
			sfr_wr_o <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (run_reg && !fetch_req_o && start_cnt_reg ==
					`RAU_START_STATES - 4'h1 && pc_reg ==
					`RAU_RESET_VECTOR && program_status_word_o[15] == 1'b0) begin
					// first fetch after reset
					program_status_word_o[15] <= 1'b1;
					state_reg <= ST_FETCH;
				end else if (op_valid_i && run_reg) begin
					op_reg <= op_code_i;
					dst_reg <= op_dst_i;
					src_reg <= op_src_i;
					size_reg <= op_size_i;
					src_sfr_reg <= src_sfr;
					dst_sfr_reg <= dst_sfr;
					src_zero_reg <= src_zero;
					push_reg <= op_push_i;
					pop_reg <= op_pop_i;
					jump_reg <= op_jump_i;
					offs_reg <= op_jump_offs_i;
					loop_reg <= op_shift_i[LOOP_W-1:0];
					sfr_rd_o <= src_sfr;
					sfr_addr_o <= op_src_i;
					state_reg <= ST_READ;
				end
			end
			ST_READ: begin
				// first operand is the destination's old value
				tmp_a_reg <= {1'b0, ram_rdata};
				state_reg <= ST_EXEC;
			end
			ST_EXEC: begin
				if (jump_reg) begin
					op_done_o <= 1'b1;
					pc_reg <= jump_sum[15:0];
					state_reg <= ST_FETCH;
				end else if (is_shift) begin
					upper_reg <= {1'b0, dbus};
					lower_reg <= ram_rdata;
					state_reg <= ST_SHIFT;
				end else begin
					result_o <= alu_out[15:0];
					program_status_word_o[0] <= alu_out[16];
					program_status_word_o[1] <= (alu_out[15:0] == 16'h0000);
					state_reg <= ST_WRITE;
				end
			end
			ST_SHIFT: begin
				if (loop_reg == {LOOP_W{1'b0}}) begin
					result_o <= upper_reg[15:0];
					program_status_word_o[0] <= upper_reg[16];
					state_reg <= ST_WRITE;
				end else begin
					loop_reg <= loop_reg - {{(LOOP_W-1){1'b0}}, 1'b1};
					if (op_reg == `RAU_OP_SHL) begin
						upper_reg <= {upper_reg[15:0],
							dbl ? lower_reg[15] : 1'b0};
						if (dbl) begin
							lower_reg <= {lower_reg[14:0], 1'b0};
						end
					end else begin
						upper_reg <= {upper_reg[0], 1'b0, upper_reg[15:1]};
						if (dbl) begin
							lower_reg <= {upper_reg[0], lower_reg[15:1]};
						end
					end
				end
			end
			ST_WRITE: begin
				if (dst_sfr_reg) begin
					sfr_wr_o <= 1'b1;
					sfr_addr_o <= dst_reg;
					sfr_wdata_o <= result_o;
				end
				if (dst_reg == `RAU_SP_LO) begin
					stack_pointer_o <= result_o;
				end
				if (push_reg) begin
					stack_pointer_o <= sp_dec;
				end else if (pop_reg) begin
					stack_pointer_o <= sp_inc;
				end
				op_done_o <= 1'b1;
				pc_reg <= pc_inc;
				state_reg <= ST_FETCH;
			end
			ST_FETCH: begin
				fetch_req_o <= 1'b1;
				program_counter_o <= pc_reg;
				// internal space never holds code
				fetch_ext_o <= (pc_reg <= `RAU_INT_SPACE_LAST);
				abus_o <= pc_reg[15:8];
				abus_hi_o <= 1'b1;
				state_reg <= ST_FLO;
			end
			ST_FLO: begin
				abus_o <= pc_reg[7:0];
				abus_hi_o <= 1'b0;
				if (fetch_ack_i) begin
					fetch_req_o <= 1'b0;
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// ram port steering
	// ------------------------------------------------------------
	always @* begin
		ram_raddr = (state_reg == ST_IDLE) ? op_dst_i : src_reg;
		ram_waddr = dst_reg;
		ram_wdata = result_o;
		ram_wbe = 2'h0;
		if (state_reg == ST_READ) begin
			ram_raddr = src_reg;
		end
		if (state_reg == ST_WRITE && !dst_sfr_reg &&
			dst_reg >= `RAU_RAM_FIRST && run_reg) begin
			ram_wbe = (size_reg == 2'h0) ? 2'h1 : 2'h3;
		end
		if (push_reg && state_reg == ST_WRITE) begin
			ram_wbe = 2'h0;
		end
	end
endmodule // rau_core
`default_nettype wire

/* rtl/rau_phase_gen.v */
// three-phase state-time generator
`timescale 1ns/1ps
`default_nettype none
`include "rau_regs.vh"
module rau_phase_gen (
	input wire mclk_i,
	input wire rst_n_i,
	output wire phase_a_o,
	output wire phase_b_o,
	output wire phase_c_o,
	output wire state_end_o
);
	reg [1:0] phase_reg;
	// restarts at phase a so several devices line up after reset
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= 2'h0;
		end else if (phase_reg == `RAU_PHASES - 2'h1) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign phase_a_o = (phase_reg == 2'h0);
	assign phase_b_o = (phase_reg == 2'h1);
	assign phase_c_o = (phase_reg == 2'h2);
	assign state_end_o = phase_c_o;
endmodule // rau_phase_gen
`default_nettype wire

/* rtl/rau_reg_ram.v */
// register file byte storage with registered two-byte read
`timescale 1ns/1ps
`default_nettype none
module rau_reg_ram #(
	parameter DEPTH = 256
) (
	input wire mclk_i,
	input wire [7:0] raddr_i,
	output reg [15:0] rdata_o,
	input wire [7:0] waddr_i,
	input wire [15:0] wdata_i,
	input wire [1:0] wbe_i
);
	reg [7:0] mem [0:DEPTH-1];
	// no reset: the retained top bytes must survive reset
	always @(posedge mclk_i) begin
		if (wbe_i[0]) begin
			mem[waddr_i] <= wdata_i[7:0];
		end
		if (wbe_i[1]) begin
			mem[waddr_i + 8'h01] <= wdata_i[15:8];
		end
		rdata_o <= {mem[raddr_i + 8'h01], mem[raddr_i]};
	end
endmodule // rau_reg_ram
`default_nettype wire

/* rtl/rau_regs.vh */
// register space offsets, reset values and timing counts
`ifndef RAU_REGS_VH
`define RAU_REGS_VH
`define RAU_SFR_LAST 8'h17
`define RAU_SP_LO 8'h18
`define RAU_SP_HI 8'h19
`define RAU_ZERO_REG 8'h00
`define RAU_RAM_FIRST 8'h18
`define RAU_KEEP_FIRST 8'hF0
`define RAU_PHASES 2'h3
`define RAU_RESET_STATES 4'h2
`define RAU_START_STATES 4'hA
`define RAU_RESET_VECTOR 16'h2080
`define RAU_INT_SPACE_LAST 16'h00FF
`define RAU_OP_ADD 3'h0
`define RAU_OP_SUB 3'h1
`define RAU_OP_AND 3'h2
`define RAU_OP_OR 3'h3
`define RAU_OP_XOR 3'h4
`define RAU_OP_PASS 3'h5
`define RAU_OP_SHL 3'h6
`define RAU_OP_SHR 3'h7
`endif
